// file: rtl/sar_adc_control_regs.sv
`timescale 1ns/100ps
module sar_adc_control_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Trigger from the PWM generator
    input wire logic pwm_trig_i,
    // Analog core
    input wire logic [11:0] conv_result_i,
    output logic conv_power_on_o,
    output logic conv_run_o,
    output logic conv_clk_en_o,
    output logic [11:0] ext_channel_en_o,
    output logic [1:0] opamp_channel_en_o,
    output logic internal_channel_en_o,
    output logic int_high_ref_en_o,
    output logic [1:0] high_ref_level_o,
    output logic ext_high_ref_sel_o,
    output logic ext_low_ref_sel_o,
    // Pure analog pin configuration
    output logic [3:0] port2_pure_analog_o,
    output logic [7:0] port3_pure_analog_o,
    output logic [7:0] port4_pure_analog_o,
    output logic [5:0] port5_pure_analog_o,
    // Interrupt request to the controller
    output logic conv_irq_o
);
    import conv_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic conv_power_on_ff;
    logic conv_start_cmd_ff;
    logic conv_done_ff;
    logic [4:0] input_channel_sel_ff;
    logic channel_global_gate_ff;
    logic [1:0] conv_clock_div_sel_ff;
    logic ext_high_ref_sel_ff;
    logic ext_low_ref_sel_ff;
    logic pwm_trigger_start_en_ff;
    logic supply_ref_force_ff;
    logic [1:0] internal_ref_level_sel_ff;
    logic [3:0] port2_cfg_ff;
    logic [7:0] port3_cfg_ff;
    logic [7:0] port4_cfg_ff;
    logic [5:0] port5_cfg_ff;
    logic conv_irq_enable_ff;
    logic conv_irq_flag_ff;
    logic [11:0] result_ff;
    logic start_pulse_ff;
    logic [IDX_W-1:0] idx;
    logic bus_req;
    logic wr_en;
    logic [7:0] wdat;
    logic sw_start;
    logic start_req;
    logic start_ok;
    logic abort;
    logic seq_busy;
    logic seq_done;
    logic seq_tick;
    logic [7:0] nxt_rdata;

    assign idx = adr_i[9:2];
    assign bus_req = cyc_i && stb_i;
    // A write lands on the edge at which the master samples ack.
    assign wr_en = bus_req && we_i && ack_o && sel_i[0];
    assign wdat = dat_i[7:0];

    // ---------------------------------------------------------------
    // Start arbitration
    // ---------------------------------------------------------------
    // Software or an enabled PWM trigger may request a conversion.
    assign sw_start = wr_en && (idx == MODE_IDX) && wdat[START_BIT];
    assign start_req = sw_start || (pwm_trig_i && pwm_trigger_start_en_ff);
    // Requests while unpowered or busy are dropped.
    assign start_ok = start_req && conv_power_on_ff && !seq_busy && !start_pulse_ff;
    // Removing power mid-conversion abandons it without a result.
    assign abort = !conv_power_on_ff;

    // ---------------------------------------------------------------
    // Wishbone handshake
    // ---------------------------------------------------------------
    // Ack rises one cycle after the request and drops after one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= bus_req && !ack_o;
        end
    end

    // Read multiplexer; unmapped indexes read as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (idx == MODE_IDX) begin
            nxt_rdata = {conv_power_on_ff, conv_start_cmd_ff, conv_done_ff, input_channel_sel_ff};
        end else if (idx == RES_HIGH_IDX) begin
            nxt_rdata = result_ff[11:4];
        end else if (idx == AUX_IDX) begin
            nxt_rdata = {1'b0, channel_global_gate_ff, conv_clock_div_sel_ff, result_ff[3:0]};
        end else if (idx == REF_IDX) begin
            nxt_rdata = {ext_high_ref_sel_ff, ext_low_ref_sel_ff, 1'b0, pwm_trigger_start_en_ff,
                         1'b0, supply_ref_force_ff, internal_ref_level_sel_ff};
        end else if (idx == PORT2_IDX) begin
            nxt_rdata = {port2_cfg_ff, 4'h0};
        end else if (idx == PORT3_IDX) begin
            nxt_rdata = port3_cfg_ff;
        end else if (idx == PORT4_IDX) begin
            nxt_rdata = port4_cfg_ff;
        end else if (idx == PORT5_IDX) begin
            nxt_rdata = {2'h0, port5_cfg_ff};
        end else if (idx == IRQ_EN2_IDX) begin
            nxt_rdata = {4'h0, conv_irq_enable_ff, 3'h0};
        end else if (idx == IRQ_REQ2_IDX) begin
            nxt_rdata = {5'h00, conv_irq_flag_ff, 2'h0};
        end
    end

    // Read data is registered with the ack and stands while ack is high.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (ce_i) begin
            dat_o <= (bus_req && !we_i && !ack_o) ? {24'h000000, nxt_rdata} : 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // Mode register: power, start and done
    // ---------------------------------------------------------------
    // Power bit and channel field are plain software fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_power_on_ff <= RESET_BIT;
            input_channel_sel_ff <= CHAN_RST;
        end else if (ce_i && wr_en && idx == MODE_IDX) begin
            conv_power_on_ff <= wdat[POWER_BIT];
            input_channel_sel_ff <= wdat[CHAN_LSB +: CHAN_W];
        end
    end

    // Start bit stays set while a conversion is pending or running.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_start_cmd_ff <= RESET_BIT;
            start_pulse_ff <= 1'b0;
        end else if (ce_i) begin
            start_pulse_ff <= start_ok;
            if (start_ok) begin
                conv_start_cmd_ff <= 1'b1;
            end else if (seq_done || abort) begin
                conv_start_cmd_ff <= 1'b0;
            end
        end
    end

    // Done bit: cleared by a start, set at completion, which beats a clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_done_ff <= RESET_BIT;
        end else if (ce_i) begin
            if (seq_done) begin
                conv_done_ff <= 1'b1;
            end else if (start_ok) begin
                conv_done_ff <= 1'b0;
            end else if (wr_en && idx == MODE_IDX) begin
                conv_done_ff <= wdat[DONE_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // Auxiliary and reference registers
    // ---------------------------------------------------------------
    // Channel gate and converter clock divider.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_global_gate_ff <= RESET_BIT;
            conv_clock_div_sel_ff <= CLKDIV_RST;
        end else if (ce_i && wr_en && idx == AUX_IDX) begin
            channel_global_gate_ff <= wdat[GATE_BIT];
            conv_clock_div_sel_ff <= wdat[CLKDIV_LSB +: 2];
        end
    end

    // Reference sources, PWM trigger enable and internal level.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_high_ref_sel_ff <= RESET_BIT;
            ext_low_ref_sel_ff <= RESET_BIT;
            pwm_trigger_start_en_ff <= RESET_BIT;
            supply_ref_force_ff <= RESET_BIT;
            internal_ref_level_sel_ff <= LEVEL_RST;
        end else if (ce_i && wr_en && idx == REF_IDX) begin
            ext_high_ref_sel_ff <= wdat[EXT_HIGH_BIT];
            ext_low_ref_sel_ff <= wdat[EXT_LOW_BIT];
            pwm_trigger_start_en_ff <= wdat[PWM_EN_BIT];
            supply_ref_force_ff <= wdat[SUPPLY_BIT];
            internal_ref_level_sel_ff <= wdat[LEVEL_LSB +: 2];
        end
    end

    // ---------------------------------------------------------------
    // Pin configuration registers
    // ---------------------------------------------------------------
    // Each set bit isolates its pin's digital input.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port2_cfg_ff <= PORT_CFG_RST[3:0];
            port3_cfg_ff <= PORT_CFG_RST;
            port4_cfg_ff <= PORT_CFG_RST;
            port5_cfg_ff <= PORT_CFG_RST[5:0];
        end else if (ce_i && wr_en) begin
            if (idx == PORT2_IDX) begin
                port2_cfg_ff <= wdat[PORT2_LSB +: 4];
            end else if (idx == PORT3_IDX) begin
                port3_cfg_ff <= wdat;
            end else if (idx == PORT4_IDX) begin
                port4_cfg_ff <= wdat;
            end else if (idx == PORT5_IDX) begin
                port5_cfg_ff <= wdat[PORT5_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Interrupt enable and flag
    // ---------------------------------------------------------------
    // Enable bit is a plain software field.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_irq_enable_ff <= RESET_BIT;
        end else if (ce_i && wr_en && idx == IRQ_EN2_IDX) begin
            conv_irq_enable_ff <= wdat[IRQ_EN_BIT];
        end
    end

    // Flag is set at completion; a same-cycle software clear loses.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_irq_flag_ff <= RESET_BIT;
        end else if (ce_i) begin
            if (seq_done) begin
                conv_irq_flag_ff <= 1'b1;
            end else if (wr_en && idx == IRQ_REQ2_IDX) begin
                conv_irq_flag_ff <= wdat[IRQ_FLAG_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // Result capture
    // ---------------------------------------------------------------
    // Result is loaded only at a completed conversion; no reset value.
    always_ff @(posedge clk_i) begin
        if (ce_i && seq_done) begin
            result_ff <= conv_result_i;
        end
    end

    // ---------------------------------------------------------------
    // Conversion timing
    // ---------------------------------------------------------------
    conv_clk_divider u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(seq_busy),
        .div_sel_i(conv_clock_div_sel_ff),
        .tick_o(seq_tick)
    );

    // Sixteen quarter-rate periods equal sixty-four converter clocks.
    conv_sequencer #(
        .TICKS(CONV_TICKS)
    ) u_sequencer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(start_pulse_ff),
        .abort_i(abort),
        .tick_i(seq_tick),
        .busy_o(seq_busy),
        .done_o(seq_done)
    );

    // ---------------------------------------------------------------
    // Analog side outputs
    // ---------------------------------------------------------------
    // Core controls are registered copies of the decoded settings.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_power_on_o <= 1'b0;
            conv_run_o <= 1'b0;
            conv_clk_en_o <= 1'b0;
            int_high_ref_en_o <= 1'b1;
            high_ref_level_o <= LEVEL_RST;
            ext_high_ref_sel_o <= 1'b0;
            ext_low_ref_sel_o <= 1'b0;
            conv_irq_o <= 1'b0;
        end else if (ce_i) begin
            conv_power_on_o <= conv_power_on_ff;
            conv_run_o <= seq_busy;
            conv_clk_en_o <= seq_tick && seq_busy;
            int_high_ref_en_o <= !ext_high_ref_sel_ff;
            high_ref_level_o <= supply_ref_force_ff ? LEVEL_SUPPLY : internal_ref_level_sel_ff;
            ext_high_ref_sel_o <= ext_high_ref_sel_ff;
            ext_low_ref_sel_o <= ext_low_ref_sel_ff;
            conv_irq_o <= conv_irq_flag_ff && conv_irq_enable_ff;
        end
    end

    // Pure analog masks follow the configuration registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port2_pure_analog_o <= PORT_CFG_RST[3:0];
            port3_pure_analog_o <= PORT_CFG_RST;
            port4_pure_analog_o <= PORT_CFG_RST;
            port5_pure_analog_o <= PORT_CFG_RST[5:0];
        end else if (ce_i) begin
            port2_pure_analog_o <= port2_cfg_ff;
            port3_pure_analog_o <= port3_cfg_ff;
            port4_pure_analog_o <= port4_cfg_ff;
            port5_pure_analog_o <= port5_cfg_ff;
        end
    end

    // External channel switches: one per pin, closed only when gated.
    genvar ch;
    generate
        for (ch = 0; ch < EXT_CH_N; ch = ch + 1) begin : g_ext_ch
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ext_channel_en_o[ch] <= 1'b0;
                end else if (ce_i) begin
                    ext_channel_en_o[ch] <= channel_global_gate_ff && (input_channel_sel_ff == 5'(ch));
                end
            end
        end
    endgenerate

    // Internal channels; reserved codes close no switch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opamp_channel_en_o <= 2'h0;
            internal_channel_en_o <= 1'b0;
        end else if (ce_i) begin
            opamp_channel_en_o[0] <= channel_global_gate_ff && (input_channel_sel_ff == CH_OPAMP0);
            opamp_channel_en_o[1] <= channel_global_gate_ff && (input_channel_sel_ff == CH_OPAMP1);
            internal_channel_en_o <= channel_global_gate_ff && (input_channel_sel_ff == CH_INTERNAL);
        end
    end
endmodule

// file: rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    // ---------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam int IDX_W = 8;
    localparam logic [7:0] IRQ_EN2_IDX = 8'h9A;
    localparam logic [7:0] PORT2_IDX = 8'h9E;
    localparam logic [7:0] PORT3_IDX = 8'h9F;
    localparam logic [7:0] IRQ_REQ2_IDX = 8'hBF;
    localparam logic [7:0] MODE_IDX = 8'hD2;
    localparam logic [7:0] RES_HIGH_IDX = 8'hD3;
    localparam logic [7:0] AUX_IDX = 8'hD4;
    localparam logic [7:0] REF_IDX = 8'hD5;
    localparam logic [7:0] PORT4_IDX = 8'hD6;
    localparam logic [7:0] PORT5_IDX = 8'hD7;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int POWER_BIT = 7;
    localparam int START_BIT = 6;
    localparam int DONE_BIT = 5;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 5;
    localparam int GATE_BIT = 6;
    localparam int CLKDIV_LSB = 4;
    localparam int EXT_HIGH_BIT = 7;
    localparam int EXT_LOW_BIT = 6;
    localparam int PWM_EN_BIT = 4;
    localparam int SUPPLY_BIT = 2;
    localparam int LEVEL_LSB = 0;
    localparam int IRQ_EN_BIT = 3;
    localparam int IRQ_FLAG_BIT = 2;
    localparam int PORT2_LSB = 4;
    localparam int PORT5_W = 6;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic RESET_BIT = 1'b0;
    localparam logic [4:0] CHAN_RST = 5'h00;
    localparam logic [1:0] CLKDIV_RST = 2'h0;
    localparam logic [1:0] LEVEL_RST = 2'h0;
    localparam logic [7:0] PORT_CFG_RST = 8'h00;

    // ---------------------------------------------------------------
    // Encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] DIV16_SEL = 2'h0;
    localparam logic [1:0] DIV8_SEL = 2'h1;
    localparam logic [1:0] DIV1_SEL = 2'h2;
    localparam logic [1:0] DIV2_SEL = 2'h3;
    localparam logic [1:0] LEVEL_SUPPLY = 2'h3;
    localparam logic [4:0] CH_EXT_LAST = 5'h0B;
    localparam logic [4:0] CH_OPAMP0 = 5'h18;
    localparam logic [4:0] CH_OPAMP1 = 5'h19;
    localparam logic [4:0] CH_INTERNAL = 5'h1A;
    localparam int EXT_CH_N = 12;

    // ---------------------------------------------------------------
    // Timing: periods of the converter clock divided by four
    // ---------------------------------------------------------------
    localparam int CONV_PERIODS = 16;
    localparam int CONV_CLK_PER_PERIOD = 4;
    localparam int CONV_TICKS = CONV_PERIODS * CONV_CLK_PER_PERIOD;

    typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_type;

endpackage

// file: rtl/conv_clk_divider.sv
`timescale 1ns/100ps
module conv_clk_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic run_i,
    input wire logic [1:0] div_sel_i,
    // Converter clock enable
    output logic tick_o
);
    import conv_ctrl_pkg::*;

    logic [3:0] cnt_ff;
    logic [3:0] term;

    // Terminal count of the prescaler for each divide setting.
    always_comb begin
        case (div_sel_i)
            DIV16_SEL: term = 4'hF;
            DIV8_SEL: term = 4'h7;
            DIV1_SEL: term = 4'h0;
            default: term = 4'h1;
        endcase
    end

    // Prescaler restarts whenever no conversion runs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (!run_i || cnt_ff >= term) begin
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            tick_o <= run_i && (cnt_ff >= term);
        end
    end
endmodule

// file: rtl/conv_sequencer.sv
`timescale 1ns/100ps
module conv_sequencer #(
    parameter int TICKS = conv_ctrl_pkg::CONV_TICKS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    import conv_ctrl_pkg::*;

    seq_state_type state_ff;
    logic [7:0] cnt_ff;

    // Counts converter clock periods from start to end of conversion.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= SEQ_IDLE;
            cnt_ff <= 8'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            case (state_ff)
                SEQ_IDLE: begin
                    cnt_ff <= 8'h00;
                    if (start_i) begin
                        state_ff <= SEQ_RUN;
                        busy_o <= 1'b1;
                    end
                end
                default: begin
                    if (abort_i) begin
                        state_ff <= SEQ_IDLE;
                        busy_o <= 1'b0;
                    end else if (tick_i) begin
                        if (cnt_ff == 8'(TICKS - 1)) begin
                            state_ff <= SEQ_IDLE;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end else begin
                            cnt_ff <= cnt_ff + 8'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// file: tb/adc_core_model.sv
`timescale 1ns/100ps
module adc_core_model (
    // Clock and control
    input wire logic clk_i,
    input wire logic run_i,
    // Sample to the design
    output logic [11:0] result_o
);
    logic [11:0] val_ff = 12'h5A3;
    // The input drifts while idle and is held still through a conversion.
    always_ff @(posedge clk_i) begin
        if (!run_i) val_ff <= val_ff + 12'h3C7;
    end
    // Outside a conversion the output is no valid sample.
    assign result_o = run_i ? val_ff : ~val_ff;
endmodule

// file: tb/adc_ctrl_props.sv
`timescale 1ns/100ps
module adc_ctrl_props (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic conv_power_on_o,
    input wire logic conv_run_o,
    input wire logic conv_clk_en_o,
    input wire logic [11:0] ext_channel_en_o,
    input wire logic [1:0] opamp_channel_en_o,
    input wire logic internal_channel_en_o,
    input wire logic int_high_ref_en_o,
    input wire logic ext_high_ref_sel_o,
    input wire logic conv_irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [7:0] ticks_ff;
    // Counts converter clock pulses within one conversion.
    always_ff @(posedge clk_i) begin
        if (rst_i || !conv_run_o) ticks_ff <= 8'h00;
        else if (conv_clk_en_o) ticks_ff <= ticks_ff + 8'h01;
    end
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_data_width: assert property (dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_one_channel: assert property ($onehot0({internal_channel_en_o, opamp_channel_en_o, ext_channel_en_o}))
        else $error("several channels");
    a_ref_mirror: assert property (int_high_ref_en_o != ext_high_ref_sel_o) else $error("ref select");
    a_tick_in_run: assert property (conv_clk_en_o |-> conv_run_o) else $error("tick while idle");
    a_run_power: assert property (!conv_power_on_o |=> !$rose(conv_run_o)) else $error("run unpowered");
    a_tick_count: assert property ($fell(conv_run_o) && conv_power_on_o |-> ticks_ff inside {[8'h3F:8'h40]})
        else $error("tick count");
    a_reset_out: assert property ($fell(rst_i) |-> !conv_irq_o && !conv_power_on_o && int_high_ref_en_o)
        else $error("reset outputs");
    c_conv_end: cover property ($fell(conv_run_o));
    c_irq_rise: cover property ($rose(conv_irq_o));
    c_internal: cover property (internal_channel_en_o);
endmodule
bind sar_adc_control_regs adc_ctrl_props u_adc_ctrl_props (.*);

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import conv_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pwm = 1'b0, ack, run, irq, ihr, ehr, elr, intc, pwr;
    logic [9:0] adr = 10'h000;
    logic [31:0] wd = 32'h0, dat_o, e, seed = 32'h0000FFAA;
    logic [11:0] res, ext, er;
    logic [1:0] opa, lvl;
    logic [3:0] p2;
    logic [7:0] p3, p4, q;
    logic [5:0] p5;
    logic [7:0] ra[10] = '{MODE_IDX, AUX_IDX, REF_IDX, PORT2_IDX, PORT3_IDX, PORT4_IDX, PORT5_IDX,
        IRQ_EN2_IDX, IRQ_REQ2_IDX, 8'h00};
    logic [7:0] wm[10] = '{8'h1F, 8'h70, 8'hD7, 8'hF0, 8'hFF, 8'hFF, 8'h3F, 8'h08, 8'h04, 8'h00};
    logic [7:0] mv[10];
    int dt[4] = '{16, 8, 1, 2};
    int mismatches = 0, compares = 0, el;
    longint t0;
    // Clock, core model, design and the captured sample of each conversion.
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (run === 1'b1) er <= res;
    adc_core_model u_adc_core_model (.clk_i(clk_i), .run_i(run), .result_o(res));
    sar_adc_control_regs u_sar_adc_control_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(dat_o), .ack_o(ack),
        .pwm_trig_i(pwm), .conv_result_i(res), .conv_power_on_o(pwr), .conv_run_o(run), .conv_clk_en_o(),
        .ext_channel_en_o(ext), .opamp_channel_en_o(opa), .internal_channel_en_o(intc),
        .int_high_ref_en_o(ihr), .high_ref_level_o(lvl), .ext_high_ref_sel_o(ehr), .ext_low_ref_sel_o(elr),
        .port2_pure_analog_o(p2), .port3_pure_analog_o(p3), .port4_pure_analog_o(p4),
        .port5_pure_analog_o(p5), .conv_irq_o(irq));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wd} <= {2'h3, w, a, 2'h0, 24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o[7:0];
        {cyc, stb, we} <= 3'h0;
        if (n >= 20) begin
            mismatches++;
            complete_run();
        end
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        wb(1'b0, a, 8'h00);
        chk(q & m, x);
    endtask
    task automatic pulse();
        pwm <= 1'b1;
        @(posedge clk_i);
        pwm <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ra[i]) rd(ra[i], i == 1 ? 8'hF0 : 8'hFF, 8'h00);
        repeat (4) begin
            foreach (ra[i]) begin
                mv[i] = rnd() & wm[i];
                wb(1'b1, ra[i], mv[i]);
            end
            foreach (ra[i]) rd(ra[i], i == 1 ? 8'hF0 : 8'hFF, mv[i]);
            e = {mv[3][7:4], mv[4], mv[5], mv[6][5:0], ~mv[2][7], mv[2][7:6], mv[2][2] ? 2'h3 : mv[2][1:0]};
            chk({p2, p3, p4, p5, ihr, ehr, elr, lvl}, e);
        end
        wb(1'b1, AUX_IDX, 8'h40);
        for (int c = 0; c < 32; c++) begin
            e = (c < 12) ? 32'h1 << c : (c > 23 && c < 27) ? 32'h1 << (c - 12) : 32'h0;
            wb(1'b1, MODE_IDX, c[7:0]);
            @(posedge clk_i);
            chk({intc, opa, ext}, e);
        end
        wb(1'b1, MODE_IDX, 8'h05);
        wb(1'b1, AUX_IDX, 8'h00);
        @(posedge clk_i);
        chk({intc, opa, ext}, 32'h0);
        wb(1'b1, IRQ_REQ2_IDX, 8'h00);
        wb(1'b1, REF_IDX, 8'h04);
        wb(1'b1, MODE_IDX, 8'hC5);
        repeat (3) @(posedge clk_i);
        chk(run, 1'b0);
        for (int d = 0; d < 4; d++) begin
            wb(1'b1, AUX_IDX, {2'h1, d[1:0], 4'h0});
            wb(1'b1, MODE_IDX, 8'h85);
            wb(1'b1, IRQ_EN2_IDX, 8'h08);
            t0 = $time;
            if (d == 3) begin
                pulse();
                chk(run, 1'b0);
                wb(1'b1, REF_IDX, 8'h14);
                t0 = $time;
                pulse();
                chk(run, 1'b1);
            end else begin
                wb(1'b1, MODE_IDX, 8'hC5);
                rd(MODE_IDX, 8'hE0, 8'hC0);
                wb(1'b1, MODE_IDX, 8'hC5);
            end
            q = 8'h00;
            for (int n = 0; q[DONE_BIT] !== 1'b1; n++) begin
                if (n == 400) begin
                    mismatches++;
                    complete_run();
                end
                wb(1'b0, MODE_IDX, 8'h00);
            end
            el = int'(($time - t0) / 10);
            chk(el >= 64 * dt[d] && el < 64 * dt[d] + 16, 1'b1);
            rd(MODE_IDX, 8'h60, 8'h20);
            rd(RES_HIGH_IDX, 8'hFF, er[11:4]);
            rd(AUX_IDX, 8'h0F, {4'h0, er[3:0]});
            rd(IRQ_REQ2_IDX, 8'h04, 8'h04);
            chk(irq, 1'b1);
            wb(1'b1, IRQ_EN2_IDX, 8'h00);
            @(posedge clk_i);
            chk(irq, 1'b0);
            wb(1'b1, IRQ_REQ2_IDX, 8'h00);
            rd(IRQ_REQ2_IDX, 8'h04, 8'h00);
        end
        // Removing power right after a start abandons the conversion.
        wb(1'b1, MODE_IDX, 8'hC5);
        wb(1'b1, MODE_IDX, 8'h05);
        rd(MODE_IDX, 8'hE0, 8'h00);
        chk({pwr, run}, 2'h0);
        complete_run();
    end
endmodule
